//--- include/tbas_defines.svh
// Constants of the tilt ball auto shut-off block: timing, counts and encodings.
`ifndef TBAS_DEFINES_SVH
`define TBAS_DEFINES_SVH

// ****************************************************************
// Clock and sampling
// ****************************************************************
`define TBAS_CLK_MHZ        200
`define TBAS_SAMPLE_US      15600
`define TBAS_SAMPLE_CYC     (`TBAS_SAMPLE_US * `TBAS_CLK_MHZ)
`define TBAS_TICK_W         16
`define TBAS_TICK_MAX       16'hFFFF
`define TBAS_DELAY_NEVER    16'hFFFF
`define TBAS_STABLE_MATCHES 2'h2
`define TBAS_BLINK_HALF     16'h0020

// Seconds to whole sample ticks, rounded up.
`define TBAS_S2TICKS(s)     (((s) * 1000000 + `TBAS_SAMPLE_US - 1) / `TBAS_SAMPLE_US)

// ****************************************************************
// Supply monitor and driver timing
// ****************************************************************
`define TBAS_POR_FILT_US    7800
`define TBAS_POR_FILT_CYC   (`TBAS_POR_FILT_US * `TBAS_CLK_MHZ)
`define TBAS_BOOST_US       7800
`define TBAS_BOOST_CYC      (`TBAS_BOOST_US * `TBAS_CLK_MHZ)
`define TBAS_PWM_FREQ_HZ    20480
`define TBAS_PWM_PERIOD_CYC ((`TBAS_CLK_MHZ * 1000000) / `TBAS_PWM_FREQ_HZ)

// ****************************************************************
// Duty cycles in per mille, normal and boosted
// ****************************************************************
`define TBAS_DUTY_00        144
`define TBAS_DUTY_01        280
`define TBAS_DUTY_10        160
`define TBAS_DUTY_11        310
`define TBAS_BOOST_00       280
`define TBAS_BOOST_01       430
`define TBAS_BOOST_10       310
`define TBAS_BOOST_11       480

// ****************************************************************
// Still delay and extra blink delay choices in seconds
// ****************************************************************
`define TBAS_STILL_SEL_30S  3'h0
`define TBAS_STILL_SEL_1M   3'h1
`define TBAS_STILL_SEL_2M   3'h2
`define TBAS_STILL_SEL_4M   3'h3
`define TBAS_STILL_SEL_8M   3'h4
`define TBAS_STILL_SEL_10M  3'h5
`define TBAS_EXTRA_SEL_4M   2'h1
`define TBAS_EXTRA_SEL_8M   2'h2
`define TBAS_SEC_30S        30
`define TBAS_SEC_1M         60
`define TBAS_SEC_2M         120
`define TBAS_SEC_4M         240
`define TBAS_SEC_8M         480
`define TBAS_SEC_10M        600

`endif

//--- include/tbas_pkg.sv
// Types and shared decoding of the tilt ball auto shut-off block.
`include "tbas_defines.svh"

package tbas_pkg;

   // Validated or raw ball position.
   typedef enum logic [1:0] {POS_NONE, POS_UP, POS_LEVEL, POS_DOWN} tbas_pos_t;

   // High time of one driver period for a duty select, boosted or not.
   function automatic logic [13:0] duty_high(input logic [1:0] sel,
                                             input logic       boost,
                                             input int unsigned period);
      int unsigned pm;
      pm = 0;
      unique case (sel)
         2'h0: pm = boost ? `TBAS_BOOST_00 : `TBAS_DUTY_00;
         2'h1: pm = boost ? `TBAS_BOOST_01 : `TBAS_DUTY_01;
         2'h2: pm = boost ? `TBAS_BOOST_10 : `TBAS_DUTY_10;
         2'h3: pm = boost ? `TBAS_BOOST_11 : `TBAS_DUTY_11;
      endcase
      return 14'((period * pm) / 1000);
   endfunction

   // Map comparator hits to a position; no or multiple hits are between.
   function automatic tbas_pos_t classify(input logic [2:0] hits);
      tbas_pos_t p;
      p = POS_NONE;
      unique case (hits)
         3'h1:    p = POS_DOWN;
         3'h2:    p = POS_LEVEL;
         3'h4:    p = POS_UP;
         default: p = POS_NONE;
      endcase
      return p;
   endfunction

   // Still delay choice in sample ticks.
   function automatic logic [15:0] still_ticks(input logic [2:0] sel);
      logic [15:0] t;
      t = 16'(`TBAS_S2TICKS(`TBAS_SEC_10M));
      unique case (sel)
         `TBAS_STILL_SEL_30S: t = 16'(`TBAS_S2TICKS(`TBAS_SEC_30S));
         `TBAS_STILL_SEL_1M:  t = 16'(`TBAS_S2TICKS(`TBAS_SEC_1M));
         `TBAS_STILL_SEL_2M:  t = 16'(`TBAS_S2TICKS(`TBAS_SEC_2M));
         `TBAS_STILL_SEL_4M:  t = 16'(`TBAS_S2TICKS(`TBAS_SEC_4M));
         `TBAS_STILL_SEL_8M:  t = 16'(`TBAS_S2TICKS(`TBAS_SEC_8M));
         default:             t = 16'(`TBAS_S2TICKS(`TBAS_SEC_10M));
      endcase
      return t;
   endfunction

   // Extra blink delay choice in sample ticks.
   function automatic logic [15:0] extra_ticks(input logic [1:0] sel);
      logic [15:0] t;
      t = 16'h0000;
      unique case (sel)
         `TBAS_EXTRA_SEL_4M: t = 16'(`TBAS_S2TICKS(`TBAS_SEC_4M));
         `TBAS_EXTRA_SEL_8M: t = 16'(`TBAS_S2TICKS(`TBAS_SEC_8M));
         default:            t = 16'h0000;
      endcase
      return t;
   endfunction

endpackage

//--- include/tbas_drv_if.sv
// Control and output of one pulsed output driver channel.
`timescale 1ns/1ps

interface tbas_drv_if;
   logic       on;
   logic [1:0] duty_sel;
   logic       pulse;

   modport ctl (output on, output duty_sel, input pulse);
   modport drv (input on, input duty_sel, output pulse);
endinterface

//--- verilog/tbas_pulse_drv.sv
// Pulsed driver channel with a boosted duty right after switch-on.
`timescale 1ns/1ps
`include "tbas_defines.svh"

module tbas_pulse_drv #(
   parameter int unsigned PERIOD_CYC = `TBAS_PWM_PERIOD_CYC,
   parameter int unsigned BOOST_CYC  = `TBAS_BOOST_CYC
) (
   // Clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rst_b,
   // Channel
   tbas_drv_if.drv     ch
);

   logic [13:0] per_r;
   logic [20:0] boost_r;
   logic        on_r;
   logic        pulse_r;
   logic [13:0] high_cyc;

   // ****************************************************************
   // Period counter, free running at the driver frequency
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || per_r == 14'(PERIOD_CYC - 1))
         per_r <= 14'h0000;
      else
         per_r <= per_r + 14'h0001;
   end

   // ****************************************************************
   // Boost window, started when the output is switched on
   // ****************************************************************
   // A fresh switch-on gives the coil extra energy to move the contact.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         on_r    <= 1'b0;
         boost_r <= 21'h000000;
      end
      else
      begin
         on_r <= ch.on;
         if (ch.on && !on_r)
            boost_r <= 21'(BOOST_CYC);
         else if (!ch.on)
            boost_r <= 21'h000000;
         else if (boost_r != 21'h000000)
            boost_r <= boost_r - 21'h000001;
      end
   end

   assign high_cyc = tbas_pkg::duty_high(ch.duty_sel, boost_r != 21'h000000, PERIOD_CYC);

   // Pulse comes from a flop so the pin never glitches on decode.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         pulse_r <= 1'b0;
      else
         pulse_r <= ch.on && (per_r < high_cyc);
   end

   assign ch.pulse = pulse_r;

endmodule

//--- verilog/tbas_top.sv
// Evaluation logic of the tilt ball auto shut-off controller.
// Operation
// - Sample ball position every 15.6 ms.
// - Three comparators classify up, level or down.
// - Position valid after three equal samples.
// - Position mode: shut off after state delay.
// - Any validated position change restarts timing.
// - Shut-off drives the relay output.
// - Leave shut-off on new position or movement.
// - Movement flag when sample differs from previous.
// - Movement mode: shut off after still delay.
// - Up state holds while ball stays there.
// - Lamp output shows shut-off state.
// - Outputs pulsed at 20.48 kHz, boosted start.
// - Supply monitor with 7.8 ms reset filter.
// - Selectable still delay and extra blink delay.
`timescale 1ns/1ps
`include "tbas_defines.svh"

module tbas_top #(
   parameter int unsigned SAMPLE_CYC     = `TBAS_SAMPLE_CYC,
   parameter int unsigned POR_FILT_CYC   = `TBAS_POR_FILT_CYC,
   parameter int unsigned PWM_PERIOD_CYC = `TBAS_PWM_PERIOD_CYC,
   parameter int unsigned BOOST_CYC      = `TBAS_BOOST_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // Supply monitor
   input  wire logic        supply_low_threshold,
   input  wire logic        supply_high_threshold,
   // Comparator hits: bit 0 front, bit 1 middle, bit 2 end
   input  wire logic [2:0]  cmp_hits,
   // Static configuration
   input  wire logic        mode_movement,
   input  wire logic [15:0] horiz_delay,
   input  wire logic [15:0] vert_up_delay,
   input  wire logic [15:0] vert_down_delay,
   input  wire logic [2:0]  still_delay_sel,
   input  wire logic [1:0]  blink_extra_delay_sel,
   input  wire logic        duty_sel_hi,
   input  wire logic        duty_sel_lo,
   // Drivers
   output logic             relay_drive,
   output logic             lamp_drive,
   // Status
   output logic             in_reset,
   output logic             shutoff_active,
   output logic             up_state,
   output logic             level_state,
   output logic             down_state,
   output logic             move_seen
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [21:0]             div_r;
   logic                    tick_r;
   logic [20:0]             low_cnt_r;
   logic                    in_reset_r;
   logic                    clr;
   tbas_pkg::tbas_pos_t     raw_pos;
   tbas_pkg::tbas_pos_t     samp_pos_r;
   tbas_pkg::tbas_pos_t     valid_pos_r;
   tbas_pkg::tbas_pos_t     cause_r;
   logic [1:0]              same_cnt_r;
   logic                    move_r;
   logic                    change;
   logic [15:0]             still_r;
   logic [15:0]             extra_r;
   logic [15:0]             blink_r;
   logic                    blink_ph_r;
   logic                    shut_r;
   logic [15:0]             dly [3];
   logic [2:0]              expired;
   logic                    still_done;
   logic                    extra_done;

   tbas_drv_if relay_if ();
   tbas_drv_if lamp_if ();

   // ****************************************************************
   // Sample tick divider
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || div_r == 22'(SAMPLE_CYC - 1))
         div_r <= 22'h000000;
      else
         div_r <= div_r + 22'h000001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         tick_r <= 1'b0;
      else
         tick_r <= (div_r == 22'(SAMPLE_CYC - 1));
   end

   // ****************************************************************
   // Supply reset state
   // ****************************************************************
   // Short dips are ignored so mains ripple does not restart the block.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         in_reset_r <= 1'b1;
         low_cnt_r  <= 21'h000000;
      end
      else if (supply_high_threshold)
      begin
         in_reset_r <= 1'b0;
         low_cnt_r  <= 21'h000000;
      end
      else if (supply_low_threshold)
      begin
         if (low_cnt_r == 21'(POR_FILT_CYC))
            in_reset_r <= 1'b1;
         else
            low_cnt_r <= low_cnt_r + 21'h000001;
      end
      else
         low_cnt_r <= 21'h000000;
   end

   assign clr     = !rst_b || in_reset_r;
   assign raw_pos = tbas_pkg::classify(cmp_hits);
   assign change  = tick_r && (raw_pos != samp_pos_r);

   // ****************************************************************
   // Sampling, debounce and movement flag
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (clr)
      begin
         samp_pos_r  <= tbas_pkg::POS_NONE;
         valid_pos_r <= tbas_pkg::POS_NONE;
         same_cnt_r  <= 2'h0;
         move_r      <= 1'b0;
      end
      else
      begin
         move_r <= change;
         if (tick_r)
         begin
            samp_pos_r <= raw_pos;
            if (raw_pos != samp_pos_r)
               same_cnt_r <= 2'h0;
            else if (same_cnt_r != `TBAS_STABLE_MATCHES)
               same_cnt_r <= same_cnt_r + 2'h1;
            // Third equal sample in a row; a held position stays valid.
            if (raw_pos == samp_pos_r && same_cnt_r != 2'h0)
               valid_pos_r <= raw_pos;
         end
      end
   end

   // ****************************************************************
   // Per state delay counters
   // ****************************************************************
   assign dly[0] = vert_up_delay;
   assign dly[1] = horiz_delay;
   assign dly[2] = vert_down_delay;

   for (genvar i = 0; i < 3; i++)
   begin : g_state
      localparam tbas_pkg::tbas_pos_t CODE = tbas_pkg::tbas_pos_t'(i + 1);
      logic [15:0] cnt_r;

      always_ff @(posedge ref_clk)
      begin
         if (clr || valid_pos_r != CODE)
            cnt_r <= 16'h0000;
         else if (tick_r && cnt_r != `TBAS_TICK_MAX)
            cnt_r <= cnt_r + 16'h0001;
      end

      // All ones marks a state that never shuts off.
      assign expired[i] = (valid_pos_r == CODE) && (dly[i] != `TBAS_DELAY_NEVER)
                          && (cnt_r > dly[i]);
   end

   // ****************************************************************
   // Still timer for movement operation
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (clr || change)
         still_r <= 16'h0000;
      else if (tick_r && still_r != `TBAS_TICK_MAX)
         still_r <= still_r + 16'h0001;
   end

   assign still_done = still_r >= tbas_pkg::still_ticks(still_delay_sel);

   // ****************************************************************
   // Shut-off state
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (clr)
      begin
         shut_r  <= 1'b0;
         cause_r <= tbas_pkg::POS_NONE;
      end
      else if (!shut_r)
      begin
         if (mode_movement ? still_done : (|expired))
         begin
            shut_r  <= 1'b1;
            cause_r <= valid_pos_r;
         end
      end
      else if (mode_movement ? change : (valid_pos_r != cause_r))
         shut_r <= 1'b0;
   end

   // ****************************************************************
   // Lamp pattern: steady during the extra delay, then blinking
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (clr || !shut_r || !mode_movement || cause_r != tbas_pkg::POS_UP)
         extra_r <= 16'h0000;
      else if (tick_r && !extra_done)
         extra_r <= extra_r + 16'h0001;
   end

   // Only an upright shut-off in movement operation holds the lamp steady first.
   assign extra_done = !mode_movement || cause_r != tbas_pkg::POS_UP
                       || extra_r >= tbas_pkg::extra_ticks(blink_extra_delay_sel);

   // Blink phase restarts at each shut-off so the first phase is lit.
   always_ff @(posedge ref_clk)
   begin
      if (clr || !shut_r)
      begin
         blink_r    <= 16'h0000;
         blink_ph_r <= 1'b1;
      end
      else if (tick_r && extra_done)
      begin
         if (blink_r == `TBAS_BLINK_HALF - 16'h0001)
         begin
            blink_r    <= 16'h0000;
            blink_ph_r <= !blink_ph_r;
         end
         else
            blink_r <= blink_r + 16'h0001;
      end
   end

   // ****************************************************************
   // Output drivers
   // ****************************************************************
   assign relay_if.on       = shut_r;
   assign relay_if.duty_sel = {duty_sel_hi, duty_sel_lo};
   assign lamp_if.on        = shut_r && (!extra_done || blink_ph_r);
   assign lamp_if.duty_sel  = {duty_sel_hi, duty_sel_lo};

   tbas_pulse_drv #(
      .PERIOD_CYC (PWM_PERIOD_CYC),
      .BOOST_CYC  (BOOST_CYC)
   ) u_relay (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .ch      (relay_if.drv)
   );

   tbas_pulse_drv #(
      .PERIOD_CYC (PWM_PERIOD_CYC),
      .BOOST_CYC  (BOOST_CYC)
   ) u_lamp (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .ch      (lamp_if.drv)
   );

   assign relay_drive    = relay_if.pulse;
   assign lamp_drive     = lamp_if.pulse;
   assign in_reset       = in_reset_r;
   assign shutoff_active = shut_r;
   assign up_state       = valid_pos_r == tbas_pkg::POS_UP;
   assign level_state    = valid_pos_r == tbas_pkg::POS_LEVEL;
   assign down_state     = valid_pos_r == tbas_pkg::POS_DOWN;
   assign move_seen      = move_r;

endmodule

//--- tb/tbas_ball_model.sv
// Behavioural model of the rolling-ball sensor and of the relay and lamp loads.
`timescale 1ns/1ps

module tbas_ball_model (
   // Clock
   input  wire logic          ref_clk,
   // Commanded ball position, none means between two regions
   input  tbas_pkg::tbas_pos_t pos,
   output logic [2:0]         cmp_hits,
   // Loads
   input  wire logic          relay_drive,
   input  wire logic          lamp_drive,
   output int                 relay_hi,
   output int                 lamp_hi
);
   // Between two regions two comparators trip, so no single hit is seen.
   always_comb
   begin
      case (pos)
         tbas_pkg::POS_UP:    cmp_hits = 3'h4;
         tbas_pkg::POS_LEVEL: cmp_hits = 3'h2;
         tbas_pkg::POS_DOWN:  cmp_hits = 3'h1;
         default:             cmp_hits = 3'h3;
      endcase
   end

   // The coil and lamp only see energy, so high cycles are totalled.
   always @(posedge ref_clk)
   begin
      relay_hi <= relay_hi + int'(relay_drive);
      lamp_hi  <= lamp_hi + int'(lamp_drive);
   end
endmodule

//--- tb/tbas_top_chk.sv
// Port-level assertions for the tilt ball shut-off block.
`timescale 1ns/1ps

module tbas_top_chk #(
   parameter int unsigned POR_FILT_CYC = 10
) (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_b,
   // Inputs
   input wire logic       supply_low_threshold,
   input wire logic       supply_high_threshold,
   input wire logic [2:0] cmp_hits,
   input wire logic       mode_movement,
   // Outputs
   input wire logic       relay_drive,
   input wire logic       lamp_drive,
   input wire logic       in_reset,
   input wire logic       shutoff_active,
   input wire logic       up_state,
   input wire logic       level_state,
   input wire logic       down_state,
   input wire logic       move_seen
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   int low_cnt_r;

   // Low-supply run length, saturated so a long brown-out cannot wrap.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || !supply_low_threshold || supply_high_threshold)
         low_cnt_r <= 0;
      else if (low_cnt_r < 1000)
         low_cnt_r <= low_cnt_r + 1;
   end

   // First relay pulse lands within one driver period.
   sequence s_drive_start;
      ##[1:102] relay_drive;
   endsequence

   a_relay_needs_off: assert property (relay_drive |-> $past(shutoff_active))
      else $error("relay pulse without shut-off");
   a_lamp_needs_off: assert property (lamp_drive |-> $past(shutoff_active))
      else $error("lamp pulse without shut-off");
   a_relay_starts: assert property ($rose(shutoff_active) |-> s_drive_start)
      else $error("relay not driven after shut-off");
   a_move_single: assert property (move_seen |=> !move_seen)
      else $error("movement flag longer than a cycle");
   a_state_onehot: assert property ($onehot0({up_state, level_state, down_state}))
      else $error("several positions valid");
   a_up_from_end: assert property ($rose(up_state) |-> $past(cmp_hits) == 3'h4)
      else $error("up state without end hit");
   a_down_from_front: assert property ($rose(down_state) |-> $past(cmp_hits) == 3'h1)
      else $error("down state without front hit");
   a_pos_exit: assert property (!mode_movement && shutoff_active &&
      $changed({up_state, level_state, down_state}) |=> !shutoff_active)
      else $error("shut-off kept after position change");
   a_move_exit: assert property (mode_movement && move_seen |=> !shutoff_active)
      else $error("shut-off kept after movement");
   a_off_cause: assert property ($rose(shutoff_active) && !mode_movement |->
      (up_state || level_state || down_state))
      else $error("shut-off without valid position");
   a_supply_filter: assert property ($rose(in_reset) |-> low_cnt_r >= POR_FILT_CYC)
      else $error("supply reset before filter time");
   a_supply_hold: assert property (low_cnt_r >= POR_FILT_CYC + 3 |-> in_reset)
      else $error("supply reset missing");
endmodule

bind tbas_top tbas_top_chk #(.POR_FILT_CYC(POR_FILT_CYC)) tbas_top_chk_inst (
   .ref_clk(ref_clk), .rst_b(rst_b), .supply_low_threshold(supply_low_threshold),
   .supply_high_threshold(supply_high_threshold), .cmp_hits(cmp_hits),
   .mode_movement(mode_movement), .relay_drive(relay_drive), .lamp_drive(lamp_drive),
   .in_reset(in_reset), .shutoff_active(shutoff_active), .up_state(up_state),
   .level_state(level_state), .down_state(down_state), .move_seen(move_seen)
);

//--- tb/tbas_top_tb.sv
// Self-checking bench for the tilt ball shut-off block.
`timescale 1ns/1ps

module tbas_top_tb;
   localparam int T = 20;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        supply_low_threshold = 1'b0;
   logic        supply_high_threshold = 1'b0;
   logic        mode_movement = 1'b0;
   logic [15:0] horiz_delay = 16'h0005;
   logic [15:0] vert_up_delay = 16'h0005;
   logic [15:0] vert_down_delay = 16'h0003;
   logic        duty_sel_hi = 1'b0;
   logic        duty_sel_lo = 1'b0;
   logic [1:0]  blink_extra_delay_sel = 2'h0;
   logic [2:0]  cmp_hits;
   logic        relay_drive, lamp_drive, in_reset, shutoff_active;
   logic        up_state, level_state, down_state, move_seen;
   tbas_pkg::tbas_pos_t pos = tbas_pkg::POS_NONE;
   int          relay_hi, lamp_hi, miscompares, compares, cycles, r0, l0;

   always #2.5 ref_clk = ~ref_clk;

   tbas_top #(.SAMPLE_CYC(T), .POR_FILT_CYC(10), .PWM_PERIOD_CYC(100), .BOOST_CYC(300))
   tbas_top_inst (
      .ref_clk, .rst_b, .supply_low_threshold, .supply_high_threshold, .cmp_hits,
      .mode_movement, .horiz_delay, .vert_up_delay, .vert_down_delay,
      .still_delay_sel(3'h0), .blink_extra_delay_sel, .duty_sel_hi, .duty_sel_lo,
      .relay_drive, .lamp_drive, .in_reset, .shutoff_active, .up_state, .level_state,
      .down_state, .move_seen
   );

   tbas_ball_model tbas_ball_model_inst (
      .ref_clk, .pos, .cmp_hits, .relay_drive, .lamp_drive, .relay_hi, .lamp_hi
   );

   // ********
   // Tasks
   // ********
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs only move at falling edges, away from the sampling edge.
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // The first step lets a pulse from the previous call die away.
   task automatic wait_move(input int n);
      cyc(1);
      for (int i = 0; i < n && move_seen !== 1'b1; i++)
         cyc(1);
      chk(16'(move_seen), 16'h1);
   endtask

   task automatic wait_shut(input logic v, input int n);
      for (int i = 0; i < n && shutoff_active !== v; i++)
         cyc(1);
      chk(16'(shutoff_active), 16'(v));
   endtask

   // One whole driver period holds exactly the duty count of high cycles.
   task automatic duty(input int exp);
      r0 = relay_hi;
      l0 = lamp_hi;
      cyc(100);
      chk(16'(relay_hi - r0), 16'(exp));
      chk(16'(lamp_hi - l0), 16'(exp));
   endtask

   task automatic do_reset(input logic mv);
      rst_b = 1'b0;
      supply_high_threshold = 1'b0;
      mode_movement = mv;
      duty_sel_hi = mv;
      duty_sel_lo = mv;
      blink_extra_delay_sel = {1'b0, mv};
      cyc(8);
      rst_b = 1'b1;
      cyc(3);
      chk(16'({in_reset, relay_drive, shutoff_active, up_state}), 16'h8);
      supply_high_threshold = 1'b1;
      cyc(2);
      chk(16'(in_reset), 16'h0);
   endtask

   // A hang is cut short and reported through the same closing path.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         summarize();
      end
   end

   // ********
   // Tests
   // ********
   initial
   begin
      do_reset(1'b0);
      // Up: three equal samples validate, then the up delay runs out.
      pos = tbas_pkg::POS_UP;
      wait_move(T + 2);
      cyc(T);
      chk(16'({move_seen, up_state}), 16'h0);
      cyc(T - 2);
      chk(16'(up_state), 16'h0);
      cyc(2);
      chk(16'(up_state), 16'h1);
      cyc(4 * T);
      chk(16'(shutoff_active), 16'h0);
      wait_shut(1'b1, 4 * T);
      cyc(5);
      duty(28);
      cyc(300);
      duty(14);
      // A new position leaves shut-off, and level times out on its own.
      pos = tbas_pkg::POS_LEVEL;
      wait_shut(1'b0, 3 * T + 4);
      wait_shut(1'b1, 12 * T);
      chk(16'({up_state, level_state, down_state}), 16'h2);
      // Rolling ball: no state lasts long enough.
      for (int i = 0; i < 12; i++)
      begin
         pos = i[0] ? tbas_pkg::POS_LEVEL : tbas_pkg::POS_UP;
         cyc(3 * T);
         if (i > 0)
            chk(16'(shutoff_active), 16'h0);
      end
      pos = tbas_pkg::POS_DOWN;
      wait_shut(1'b1, 12 * T);
      chk(16'(down_state), 16'h1);
      pos = tbas_pkg::POS_NONE;
      wait_shut(1'b0, 3 * T + 4);
      cyc(3 * T);
      chk(16'({up_state, level_state, down_state}), 16'h0);
      // Up with an endless delay stays up and never shuts off.
      vert_up_delay = 16'hFFFF;
      pos = tbas_pkg::POS_UP;
      cyc(40 * T);
      chk(16'({up_state, shutoff_active}), 16'h2);
      // A short supply dip is filtered, a long one resets the state.
      supply_low_threshold = 1'b1;
      supply_high_threshold = 1'b0;
      cyc(5);
      supply_high_threshold = 1'b1;
      cyc(2);
      chk(16'({in_reset, up_state}), 16'h1);
      supply_high_threshold = 1'b0;
      cyc(20);
      chk(16'({in_reset, up_state}), 16'h2);
      supply_low_threshold = 1'b0;
      supply_high_threshold = 1'b1;
      cyc(2);
      chk(16'(in_reset), 16'h0);
      // Movement operation: every change flagged, then the still delay.
      do_reset(1'b1);
      pos = tbas_pkg::POS_UP;
      wait_move(T + 2);
      for (int i = 0; i < 4; i++)
      begin
         pos = tbas_pkg::tbas_pos_t'(2'(i + 2));
         wait_move(T + 2);
      end
      cyc(1920 * T);
      chk(16'(shutoff_active), 16'h0);
      wait_shut(1'b1, 8 * T);
      cyc(5);
      duty(48);
      // Upright cause: the lamp stays lit past the first blink phase.
      cyc(600);
      duty(31);
      pos = tbas_pkg::POS_LEVEL;
      wait_move(T + 2);
      cyc(1);
      chk(16'(shutoff_active), 16'h0);
      summarize();
   end
endmodule
